// ==== crc_pkg.sv ====
// Shared constants and types for the cable reflectometry controller
package crc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 20000;
  localparam int STEP_PS       = 8000;
  localparam int SHORT_PULSE_PS = 50000;
  localparam int LONG_PULSE_PS  = 100000;
  // Least times round up to whole clocks
  localparam int STEP_CYC  = (STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SHORT_CYC =
    (SHORT_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LONG_CYC  =
    (LONG_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Register map (printed index, byte address is four times it)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL   = 8'h16;
  localparam logic [7:0] IDX_WINDOW = 8'h17;
  localparam logic [7:0] IDX_PEAK   = 8'h18;
  localparam logic [7:0] IDX_THRESH = 8'h19;
  localparam logic [9:0] ADDR_CTRL   = {IDX_CTRL, 2'b00};
  localparam logic [9:0] ADDR_WINDOW = {IDX_WINDOW, 2'b00};
  localparam logic [9:0] ADDR_PEAK   = {IDX_PEAK, 2'b00};
  localparam logic [9:0] ADDR_THRESH = {IDX_THRESH, 2'b00};

  // ----------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------
  localparam int CTRL_ENABLE = 15;
  localparam int CTRL_FAST   = 14;
  localparam int CTRL_LAUNCH = 13;
  localparam int CTRL_SENSE  = 12;
  localparam int CTRL_FIRE   = 11;
  localparam int CTRL_WIDTH  = 8;
  localparam int CTRL_NEG    = 7;
  localparam int CTRL_THR    = 0;
  localparam int WIN_START   = 8;
  localparam int WIN_STOP    = 0;
  localparam int PEAK_VALUE  = 8;
  localparam int THR_HIT     = 8;
  localparam logic [15:0] CTRL_WMASK = 16'hffbf;
  localparam logic [15:0] CTRL_RESET = 16'h0020;
  localparam logic [15:0] WIN_RESET  = 16'h00ff;
  localparam logic [5:0]  SAMPLE_ZERO = 6'h00;

  typedef enum logic [1:0] {
    CRC_IDLE    = 2'b00,
    CRC_LAUNCH  = 2'b01,
    CRC_CAPTURE = 2'b11
  } crc_state_type;

  typedef struct packed {
    logic onRxPair;
    logic active;
    logic negative;
    logic linkPulse;
  } crc_drive_type;

  typedef struct packed {
    logic [5:0] peakValue;
    logic [7:0] peakTime;
    logic       thrHit;
    logic [7:0] thrTime;
  } crc_result_type;

endpackage

// ==== crc_pulse_gen.sv ====
// Diagnostic pulse launcher for the fast and link-pulse transmitters
`timescale 1ns/1ps
module crc_pulse_gen
  import crc_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  start,
  input  wire logic                  fastMode,
  input  wire logic                  onRxPair,
  input  wire logic [2:0]            width,
  output crc_pkg::crc_drive_type     drive
);

  import crc_pkg::*;

  crc_drive_type driveFf;
  logic [7:0]    remainFf;
  logic          polarityFf;
  logic [7:0]    nxt_remain;

  always_comb
  begin
    if (fastMode)
      nxt_remain = 8'(width * STEP_CYC);
    else if (width == 3'h1)
      nxt_remain = 8'(SHORT_CYC);
    else
      nxt_remain = 8'(LONG_CYC);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      remainFf <= 8'h00;
    else if (start && width != 3'h0)
      remainFf <= nxt_remain;
    else if (remainFf != 8'h00)
      remainFf <= remainFf - 8'h01;
  end

  // Fast pulses flip sign every launch
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      polarityFf <= 1'b0;
    else if (start && width != 3'h0 && fastMode)
      polarityFf <= ~polarityFf;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      driveFf <= '0;
    else if (start && width != 3'h0)
    begin
      driveFf.onRxPair  <= onRxPair;
      driveFf.active    <= 1'b1;
      driveFf.negative  <= fastMode & polarityFf;
      driveFf.linkPulse <= ~fastMode;
    end
    else if (remainFf == 8'h01)
      driveFf.active <= 1'b0;
  end

  assign drive = driveFf;

endmodule

// ==== crc_echo_monitor.sv ====
// Reflection monitor: window, peak and threshold capture
`timescale 1ns/1ps
module crc_echo_monitor
  import crc_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  arm,
  input  wire logic [5:0]            sample,
  input  wire logic                  negMode,
  input  wire logic [5:0]            threshold,
  input  wire logic [7:0]            winStart,
  input  wire logic [7:0]            winStop,
  output logic                       done,
  output crc_pkg::crc_result_type    result
);

  import crc_pkg::*;

  // True when a is beyond b in the chosen direction
  function automatic logic beyond(input logic [5:0] a,
                                  input logic [5:0] b,
                                  input logic       neg);
    beyond = neg ? (a < b) : (a > b);
  endfunction

  crc_result_type resFf;
  logic [7:0]     timeFf;
  logic [7:0]     stepCntFf;
  logic           activeFf;
  logic           seenFf;
  logic           doneFf;
  logic           stepEn;
  logic           inWin;

  assign stepEn = activeFf && stepCntFf == 8'(STEP_CYC - 1);
  assign inWin  = timeFf >= winStart && timeFf <= winStop;

  // ----------------------------------------------------------------
  // Sample clock divider and time counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      stepCntFf <= 8'h00;
    else if (arm || stepEn)
      stepCntFf <= 8'h00;
    else if (activeFf)
      stepCntFf <= stepCntFf + 8'h01;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timeFf   <= 8'h00;
      activeFf <= 1'b0;
      doneFf   <= 1'b0;
    end
    else
    begin
      doneFf <= 1'b0;
      if (arm)
      begin
        timeFf   <= 8'h00;
        activeFf <= 1'b1;
      end
      else if (stepEn)
      begin
        if (timeFf == winStop)
        begin
          activeFf <= 1'b0;
          doneFf   <= 1'b1;
        end
        else
          timeFf <= timeFf + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Peak and threshold capture
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      resFf  <= '0;
      seenFf <= 1'b0;
    end
    else if (arm)
    begin
      resFf  <= '0;
      seenFf <= 1'b0;
    end
    else if (stepEn && inWin)
    begin
      seenFf <= 1'b1;
      // Strict compare keeps the first occurrence
      if (!seenFf || beyond(sample, resFf.peakValue, negMode))
      begin
        resFf.peakValue <= sample;
        resFf.peakTime  <= timeFf;
      end
      if (!resFf.thrHit && beyond(sample, threshold, negMode))
      begin
        resFf.thrHit  <= 1'b1;
        resFf.thrTime <= timeFf;
      end
    end
  end

  assign done   = doneFf;
  assign result = resFf;

endmodule

// ==== crc_top.sv ====
// Cable reflectometry controller: register slave and test sequencer
//
// Operation
// - Enable bit forces the port into its diagnostic transmit/receive state.
// - Fast select takes the pulse from the 100Mb transmitter, 8ns steps (code: one 20ns clock per step).
// - Fast mode pulses alternate positive then negative.
// - Otherwise link-pulse generator: 50ns pre-emphasis or full 100ns pulse (code: 3 clocks = 60ns, or 5 clocks = 100ns).
// - Launch pair select: 0 transmit pair, 1 receive pair.
// - Sense pair select: 0 transmit pair, 1 receive pair.
// - Writing fire bit launches one pulse and arms the monitor.
// - Fire bit self-clears when capture completes.
// - Width field counts pulse length; 8ns per count in fast mode (code: one 20ns clock per count).
// - Link-pulse mode counts 50ns steps; only 50ns or 100ns pulses (code: 60ns for width 1, else 100ns).
// - Zero width sends nothing but the monitor still captures.
// - Negative peak mode selects detection direction for peak and threshold.
// - Trigger when sample above threshold, or below it in negative mode.
// - Six-bit offset code, midpoint 0x20; threshold resets to 0x20.
// - Control bit 6 ignores writes, reads zero; other bits reset zero except bit 5 (threshold 0x20).
// - Monitor only between start and stop times; stop resets to 0xFF.
// - Record peak sample and time of its first occurrence.
// - Record threshold hit flag and time of first crossing.
`timescale 1ns/1ps
module crc_top
  import crc_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  // Analog front end
  input  wire logic [5:0]            txPairSample,
  input  wire logic [5:0]            rxPairSample,
  output logic                       testPowerUp,
  output logic                       sensePairSel,
  output crc_pkg::crc_drive_type     pulseDrive
);

  import crc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0]    ctrlFf;
  logic [15:0]    windowFf;
  logic [15:0]    nxt_ctrl;
  logic [15:0]    nxt_window;
  logic [31:0]    nxt_rdata;
  logic [31:0]    hrdataFf;
  logic           hreadyoutFf;
  logic           hrespFf;
  logic           wrPendFf;
  logic [9:0]     wrAddrFf;
  logic           addrPhase;
  crc_state_type  stateFf;
  crc_state_type  nxt_state;
  logic           fireReq;
  logic           launchStrobe;
  logic           captureDone;
  logic           testPowerUpFf;
  logic           sensePairSelFf;
  logic [5:0]     senseSample;
  crc_result_type result;
  crc_drive_type  drive;
  logic           fastSel;
  logic           launchRx;
  logic           senseRx;
  logic [2:0]     widthSel;
  logic           negSel;
  logic [5:0]     thrSel;
  logic [7:0]     winStart;
  logic [7:0]     winStop;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Only bits 9:0 decode, so the map repeats every kilobyte
  function automatic logic regHit(input logic [9:0] addr,
                                  input logic [9:0] target);
    regHit = addr == target;
  endfunction

  // ----------------------------------------------------------------
  // Bus address phase
  // ----------------------------------------------------------------
  // Only word accesses are expected; hsize is not checked
  assign addrPhase = hsel && htrans[1] && hready;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPendFf <= 1'b0;
      wrAddrFf <= 10'h000;
    end
    else
    begin
      wrPendFf <= addrPhase && hwrite;
      if (addrPhase)
        wrAddrFf <= haddr[9:0];
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hreadyoutFf <= 1'b1;
      hrespFf     <= 1'b0;
    end
    else
    begin
      hreadyoutFf <= 1'b1;
      hrespFf     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control register next value
  // ----------------------------------------------------------------
  // Fire is only taken while idle; writes during a run leave it set
  always_comb
  begin
    nxt_ctrl = ctrlFf;
    fireReq  = 1'b0;
    if (wrPendFf && regHit(wrAddrFf, ADDR_CTRL))
    begin
      nxt_ctrl = (hwdata[15:0] & CTRL_WMASK);
      if (stateFf != CRC_IDLE)
        nxt_ctrl[CTRL_FIRE] = 1'b1;
      else
        fireReq = hwdata[CTRL_FIRE];
    end
    if (captureDone)
      nxt_ctrl[CTRL_FIRE] = 1'b0;
  end

  always_comb
  begin
    nxt_window = windowFf;
    if (wrPendFf && regHit(wrAddrFf, ADDR_WINDOW))
      nxt_window = hwdata[15:0];
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ctrlFf <= CTRL_RESET;
    else
      ctrlFf <= nxt_ctrl;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      windowFf <= WIN_RESET;
    else
      windowFf <= nxt_window;
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Taken from next values so a read right after a write sees it
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    if (regHit(haddr[9:0], ADDR_CTRL))
      nxt_rdata[15:0] = nxt_ctrl;
    else if (regHit(haddr[9:0], ADDR_WINDOW))
      nxt_rdata[15:0] = nxt_window;
    else if (regHit(haddr[9:0], ADDR_PEAK))
    begin
      nxt_rdata[PEAK_VALUE +: 6] = result.peakValue;
      nxt_rdata[7:0]             = result.peakTime;
    end
    else if (regHit(haddr[9:0], ADDR_THRESH))
    begin
      nxt_rdata[THR_HIT] = result.thrHit;
      nxt_rdata[7:0]     = result.thrTime;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      hrdataFf <= 32'h0000_0000;
    else if (addrPhase && !hwrite)
      hrdataFf <= nxt_rdata;
  end

  // ----------------------------------------------------------------
  // Test sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = stateFf;
    case (stateFf)
      CRC_IDLE:
        if (fireReq)
          nxt_state = CRC_LAUNCH;
      CRC_LAUNCH:
        nxt_state = CRC_CAPTURE;
      CRC_CAPTURE:
        if (captureDone)
          nxt_state = CRC_IDLE;
      default:
        nxt_state = CRC_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      stateFf <= CRC_IDLE;
    else
      stateFf <= nxt_state;
  end

  // Pulse and monitor start together, so time zero is the launch
  assign launchStrobe = stateFf == CRC_LAUNCH;

  // ----------------------------------------------------------------
  // Front-end controls
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      testPowerUpFf  <= 1'b0;
      sensePairSelFf <= 1'b0;
    end
    else
    begin
      testPowerUpFf  <= nxt_ctrl[CTRL_ENABLE];
      sensePairSelFf <= nxt_ctrl[CTRL_SENSE];
    end
  end

  assign senseSample = senseRx ? rxPairSample
                               : txPairSample;

  // ----------------------------------------------------------------
  // Stored control fields
  // ----------------------------------------------------------------
  // From the stored values: a pending write reaches a run one edge later
  assign fastSel  = ctrlFf[CTRL_FAST];
  assign launchRx = ctrlFf[CTRL_LAUNCH];
  assign senseRx  = ctrlFf[CTRL_SENSE];
  assign widthSel = ctrlFf[CTRL_WIDTH +: 3];
  assign negSel   = ctrlFf[CTRL_NEG];
  assign thrSel   = ctrlFf[CTRL_THR +: 6];
  assign winStart = windowFf[WIN_START +: 8];
  assign winStop  = windowFf[WIN_STOP +: 8];

  // ----------------------------------------------------------------
  // Pulse launcher and echo monitor
  // ----------------------------------------------------------------
  crc_pulse_gen u_pulse
  (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .start    (launchStrobe),
    .fastMode (fastSel),
    .onRxPair (launchRx),
    .width    (widthSel),
    .drive    (drive)
  );

  crc_echo_monitor u_monitor
  (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .arm       (launchStrobe),
    .sample    (senseSample),
    .negMode   (negSel),
    .threshold (thrSel),
    .winStart  (winStart),
    .winStop   (winStop),
    .done      (captureDone),
    .result    (result)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout    = hreadyoutFf;
  assign hresp        = hrespFf;
  assign hrdata       = hrdataFf;
  assign testPowerUp  = testPowerUpFf;
  assign sensePairSel = sensePairSelFf;
  assign pulseDrive   = drive;

endmodule

// ==== crc_monitor.sv ====
// Bus and pulse checker for the reflectometry controller
`timescale 1ns/1ps
module crc_monitor
(
  input wire logic                   mclk,
  input wire logic                   rst_n,
  input wire logic                   hsel,
  input wire logic [31:0]            haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic [31:0]            hwdata,
  input wire logic                   hready,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire logic [31:0]            hrdata,
  input wire logic                   testPowerUp,
  input wire logic                   sensePairSel,
  input wire crc_pkg::crc_drive_type pulseDrive
);
  import crc_pkg::*;
  logic        ctrlAddr_ff;
  logic [15:0] shadow_ff;
  logic        lastNeg_ff;
  logic [3:0]  actLen_ff;
  logic [3:0]  expLen;
  assign expLen = shadow_ff[CTRL_FAST] ? {1'b0, shadow_ff[10:8]} :
    (shadow_ff[10:8] == 3'h1 ? 4'(SHORT_CYC) : 4'(LONG_CYC));
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrlAddr_ff <= 1'b0;
      shadow_ff   <= 16'h0020;
    end
    else if (hready)
    begin
      ctrlAddr_ff <= hsel && htrans[1] && hwrite && haddr[9:0] == ADDR_CTRL;
      if (ctrlAddr_ff)
        shadow_ff <= hwdata[15:0];
    end
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lastNeg_ff <= 1'b1;
      actLen_ff  <= 4'h0;
    end
    else
    begin
      actLen_ff <= pulseDrive.active ? actLen_ff + 4'h1 : 4'h0;
      // Link pulses leave the fast-mode polarity where it was
      if (pulseDrive.active && actLen_ff == 4'h0 && !pulseDrive.linkPulse)
        lastNeg_ff <= pulseDrive.negative;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence fireCmd;
    ctrlAddr_ff && hwdata[CTRL_FIRE] && hwdata[10:8] != 3'h0;
  endsequence
  sequence fireBlank;
    ctrlAddr_ff && hwdata[CTRL_FIRE] && hwdata[10:8] == 3'h0;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  a_read_upper: assert property (hrdata[31:16] == 16'h0)
    else $error("read data upper half not zero");
  a_pulse_length: assert property (
    $fell(pulseDrive.active) |-> actLen_ff == expLen)
    else $error("pulse length wrong");
  a_link_positive: assert property (
    pulseDrive.active && pulseDrive.linkPulse |-> !pulseDrive.negative)
    else $error("link pulse negative");
  a_fast_alternate: assert property (
    $rose(pulseDrive.active) && !pulseDrive.linkPulse
      |-> pulseDrive.negative != lastNeg_ff)
    else $error("fast pulse polarity did not alternate");
  a_tx_source: assert property (
    $rose(pulseDrive.active) |-> pulseDrive.linkPulse != shadow_ff[14]
      && pulseDrive.onRxPair == shadow_ff[13])
    else $error("pulse source or pair wrong");
  a_level_copies: assert property (
    ctrlAddr_ff |-> ##2 testPowerUp == shadow_ff[15]
      && sensePairSel == shadow_ff[12])
    else $error("power-up or sense pair not following control");
  a_pulse_start: assert property (
    fireCmd |-> ##[2:4] $rose(pulseDrive.active))
    else $error("pulse not launched after fire");
  a_zero_width: assert property (
    fireBlank |-> ##1 (!pulseDrive.active) [*6])
    else $error("pulse launched with zero width");
endmodule
bind crc_top crc_monitor mon_u (.mclk(mclk), .rst_n(rst_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .testPowerUp(testPowerUp), .sensePairSel(sensePairSel),
  .pulseDrive(pulseDrive));

// ==== crc_cable_model.sv ====
// Cable model: one reflection on the pair that carried the pulse
`timescale 1ns/1ps
module crc_cable_model
#(
  parameter int         ECHO_DLY = 5,
  parameter logic [5:0] ECHO_AMP = 6'h10
)
(
  input wire logic                   mclk,
  input wire logic                   rst_n,
  input wire crc_pkg::crc_drive_type drive,
  output logic [5:0]                 txSample,
  output logic [5:0]                 rxSample
);
  import crc_pkg::*;
  logic [7:0] age_ff;
  logic       actPrev_ff;
  logic       pairRx_ff;
  logic       neg_ff;
  logic [5:0] echo;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      age_ff     <= 8'h0;
      actPrev_ff <= 1'b0;
      pairRx_ff  <= 1'b0;
      neg_ff     <= 1'b0;
    end
    else
    begin
      actPrev_ff <= drive.active;
      if (drive.active && !actPrev_ff)
      begin
        age_ff    <= 8'h1;
        pairRx_ff <= drive.onRxPair;
        neg_ff    <= drive.negative;
      end
      else if (age_ff != 8'h0 && age_ff != 8'hff)
        age_ff <= age_ff + 8'h1;
    end
  end
  // Quiet line sits at the midpoint; echo keeps the pulse polarity
  assign echo = neg_ff ? 6'h20 - ECHO_AMP : 6'h20 + ECHO_AMP;
  assign txSample = (age_ff == 8'(ECHO_DLY) && !pairRx_ff) ? echo : 6'h20;
  assign rxSample = (age_ff == 8'(ECHO_DLY) && pairRx_ff) ? echo : 6'h20;
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the reflectometry controller
`timescale 1ns/1ps
module tb_top;
  import crc_pkg::*;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [3:0]  len;
    logic        neg;
    logic        link;
    logic [15:0] peak;
    logic [15:0] thr;
    logic [15:0] thrMask;
  } crc_case_type;
  // Echo lands at time 6 on the launch pair; window runs 2 to 20
  localparam crc_case_type CASES [6] = '{
    '{16'hca28, 4'h2, 1'b0, 1'b0, 16'h3006, 16'h0106, 16'h01ff},
    '{16'hca98, 4'h2, 1'b1, 1'b0, 16'h1006, 16'h0106, 16'h01ff},
    '{16'hb928, 4'h3, 1'b0, 1'b1, 16'h3006, 16'h0106, 16'h01ff},
    '{16'hab28, 4'h5, 1'b0, 1'b1, 16'h2002, 16'h0000, 16'h0100},
    '{16'hcf28, 4'h7, 1'b0, 1'b0, 16'h3006, 16'h0106, 16'h01ff},
    '{16'hc828, 4'h0, 1'b0, 1'b0, 16'h2002, 16'h0000, 16'h0100}};
  localparam logic [9:0] RST_ADDR [5] = '{ADDR_CTRL, ADDR_WINDOW,
    ADDR_PEAK, ADDR_THRESH, 10'h068};
  localparam logic [15:0] RST_VAL [5] = '{16'h0020, 16'h00ff, 16'h0,
    16'h0, 16'h0};
  logic          mclk;
  logic          rst_n;
  logic          hsel;
  logic [31:0]   haddr;
  logic [1:0]    htrans;
  logic          hwrite;
  logic [2:0]    hsize;
  logic [31:0]   hwdata;
  logic          hreadyout;
  logic          hresp;
  logic [31:0]   hrdata;
  logic [5:0]    txSample;
  logic [5:0]    rxSample;
  logic          testPowerUp;
  logic          sensePairSel;
  crc_drive_type pulseDrive;
  int            num_errors;
  int            checks;
  int            cycles;
  logic [31:0]   actCnt;
  logic          negSeen;
  logic          linkSeen;
  crc_top dut_u (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .txPairSample(txSample), .rxPairSample(rxSample),
    .testPowerUp(testPowerUp), .sensePairSel(sensePairSel),
    .pulseDrive(pulseDrive));
  crc_cable_model #(.ECHO_DLY(6)) cable_u (.mclk(mclk), .rst_n(rst_n),
    .drive(pulseDrive), .txSample(txSample), .rxSample(rxSample));
  always #10 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cycles++;
    if (pulseDrive.active === 1'b1)
    begin
      actCnt   = actCnt + 32'h1;
      negSeen  = negSeen | pulseDrive.negative;
      linkSeen = linkSeen | pulseDrive.linkPulse;
    end
    if (cycles == 5000)
    begin
      num_errors++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    if (num_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [9:0] a,
                     input logic [15:0] d, output logic [31:0] r);
    @(posedge mclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {22'h0, a};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic run(input crc_case_type c);
    logic [31:0] r;
    int          n;
    actCnt   = 32'h0;
    negSeen  = 1'b0;
    linkSeen = 1'b0;
    bus(1'b1, ADDR_CTRL, c.ctrl, r);
    // A write in mid-test must not abort the capture
    bus(1'b1, ADDR_CTRL, c.ctrl & 16'hf7ff, r);
    bus(1'b0, ADDR_CTRL, 16'h0, r);
    cmp("fire held", {16'h0, c.ctrl}, r);
    n = 0;
    do
    begin
      bus(1'b0, ADDR_CTRL, 16'h0, r);
      n++;
    end
    while (r[CTRL_FIRE] !== 1'b0 && n < 100);
    cmp("fire clear", {16'h0, c.ctrl & 16'hf7ff}, r);
    cmp("pulse length", {28'h0, c.len}, actCnt);
    cmp("polarity", {31'h0, c.neg}, {31'h0, negSeen});
    cmp("link source", {31'h0, c.link}, {31'h0, linkSeen});
    cmp("sense pair", {31'h0, c.ctrl[12]}, {31'h0, sensePairSel});
    bus(1'b0, ADDR_PEAK, 16'h0, r);
    cmp("peak", {16'h0, c.peak}, r);
    bus(1'b0, ADDR_THRESH, 16'h0, r);
    cmp("threshold", {16'h0, c.thr}, r & {16'h0, c.thrMask});
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] r;
    mclk       = 1'b0;
    rst_n      = 1'b0;
    hsel       = 1'b0;
    haddr      = 32'h0;
    htrans     = 2'h0;
    hwrite     = 1'b0;
    hsize      = 3'h2;
    hwdata     = 32'h0;
    num_errors = 0;
    checks     = 0;
    cycles     = 0;
    actCnt     = 32'h0;
    negSeen    = 1'b0;
    linkSeen   = 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    cmp("drive idle", 32'h0, {28'h0, pulseDrive});
    bus(1'b1, 10'h068, 16'hffff, r);
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b0, RST_ADDR[i], 16'h0, r);
      cmp("reset value", {16'h0, RST_VAL[i]}, r);
    end
    bus(1'b1, ADDR_CTRL, 16'h007f, r);
    bus(1'b0, ADDR_CTRL, 16'h0, r);
    cmp("ctrl bit6", 32'h003f, r);
    bus(1'b1, ADDR_WINDOW, 16'h0214, r);
    bus(1'b0, ADDR_WINDOW, 16'h0, r);
    cmp("window", 32'h0214, r);
    for (int i = 0; i < 6; i++)
      run(CASES[i]);
    cmp("power up", 32'h1, {31'h0, testPowerUp});
    test_done();
  end
endmodule
